// [hw/lcdc_core.sv]
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module lcdc_core #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int POST_DIV_SYS = lcdc_pkg::POST_DIV_SYS,
  parameter int POST_DIV_SLOW = lcdc_pkg::POST_DIV_SLOW
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sleep_i,
  input wire logic low_speed_timer_osc_i,
  input wire logic internal_rc_osc_i,
  input wire logic fast_internal_osc_i,
  output logic [47:0] segment_enable_bit_o,
  output logic [47:0] seg_data_o,
  output logic [3:0] common_line_o,
  output logic display_active_o,
  output logic frame_tick_o,
  output logic pump_clk_o,
  output logic regulator_en_o,
  output logic irq_o
);

  logic [7:0] pix_r [lcdc_pkg::NUM_PIX_REG];
  logic [7:0] seg_r [lcdc_pkg::NUM_SEG_REG];
  lcdc_pkg::lcdc_ctrl_t ctrl_r;
  lcdc_pkg::lcdc_phase_t phase_r;
  lcdc_pkg::lcdc_regul_t regul_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic timer_q_r;
  logic rc_q_r;
  logic fast_q_r;
  logic [12:0] post_cnt_r;
  logic [3:0] pre_cnt_r;
  logic [1:0] com_idx_r;
  logic [1:0] com_nxt;
  logic [1:0] com_cur;
  logic [1:0] com_show;
  logic [3:0] common_line_r;
  logic [47:0] seg_data_r;
  logic frame_tick_r;
  logic [7:0] fast_div_r;
  logic pump_clk_r;

  logic active;
  logic timer_tick;
  logic rc_tick;
  logic fast_tick;
  logic src_tick;
  logic [12:0] post_limit;
  logic base_tick;
  logic step;
  logic frame_evt;
  logic write_allow;
  logic is_pix;
  logic is_seg;
  logic [4:0] pix_idx;
  logic [2:0] seg_idx;
  logic pix_wr;
  logic write_error_flag_evt;
  logic [4:0] pix_base;
  logic rd_stat;

  function automatic logic [7:0] pix_mask(input logic [4:0] idx);
    logic [4:0] pos;
    pos = 5'(idx % 5'd6);
    if (!SMALL_VARIANT) begin
      pix_mask = lcdc_pkg::MASK_ALL;
    end else if (pos == 5'd5) begin
      pix_mask = lcdc_pkg::RST_ZERO;
    end else if (pos == 5'd4) begin
      pix_mask = lcdc_pkg::MASK_SEG32;
    end else begin
      pix_mask = lcdc_pkg::MASK_ALL;
    end
  endfunction : pix_mask

  function automatic logic [7:0] seg_mask(input logic [2:0] idx);
    if (!SMALL_VARIANT) begin
      seg_mask = lcdc_pkg::MASK_ALL;
    end else if (idx == 3'd5) begin
      seg_mask = lcdc_pkg::RST_ZERO;
    end else if (idx == 3'd4) begin
      seg_mask = lcdc_pkg::MASK_SEG32;
    end else begin
      seg_mask = lcdc_pkg::MASK_ALL;
    end
  endfunction : seg_mask

  // Sleep stops the display only when the sleep-disable bit is set.
  assign active = ctrl_r.en && !(ctrl_r.sleep_off && sleep_i);

  assign is_pix = (addr_i >= lcdc_pkg::OFF_PIX0) &&
                  (addr_i < lcdc_pkg::OFF_PIX0 + 6'(lcdc_pkg::NUM_PIX_REG));
  assign is_seg = (addr_i >= lcdc_pkg::OFF_SEGEN0) &&
                  (addr_i < lcdc_pkg::OFF_SEGEN0 + 6'(lcdc_pkg::NUM_SEG_REG));
  assign pix_idx = 5'(addr_i - lcdc_pkg::OFF_PIX0);
  assign seg_idx = 3'(addr_i - lcdc_pkg::OFF_SEGEN0);
  assign rd_stat = rd_i && (addr_i == lcdc_pkg::OFF_IRQ_STAT);

  // Pixel data may not change in the cycle the commons advance, so that a
  // common never shows a half-updated row.
  assign write_allow = !(active && step);
  assign pix_wr = wr_i && is_pix && write_allow;
  assign write_error_flag_evt = wr_i && is_pix && !write_allow;

  // Clock sources are sampled levels; a rising edge is one source tick.
  assign timer_tick = low_speed_timer_osc_i && !timer_q_r;
  assign rc_tick = internal_rc_osc_i && !rc_q_r;
  assign fast_tick = fast_internal_osc_i && !fast_q_r;

  always_comb begin
    case (ctrl_r.clk_src)
      lcdc_pkg::SRC_SYS: src_tick = 1'b1;
      lcdc_pkg::SRC_TIMER: src_tick = timer_tick;
      default: src_tick = rc_tick;
    endcase
  end

  assign post_limit = (ctrl_r.clk_src == lcdc_pkg::SRC_SYS) ?
                      13'(POST_DIV_SYS - 1) : 13'(POST_DIV_SLOW - 1);
  assign base_tick = active && src_tick && (post_cnt_r >= post_limit);
  assign step = base_tick && (pre_cnt_r >= phase_r.prescale);
  // A common left beyond a newly narrowed mux range reads as common 0, so a
  // mode change lights a common that the new mode does not use for at most one cycle, from the registered common_line_r.
  assign com_cur = (com_idx_r > 2'(ctrl_r.mux)) ? 2'd0 : com_idx_r;
  assign com_nxt = (com_cur >= 2'(ctrl_r.mux)) ? 2'd0 : 2'(com_cur + 2'd1);
  assign com_show = step ? com_nxt : com_cur;
  assign frame_evt = step && (com_cur >= 2'(ctrl_r.mux));
  // Segment data is fetched for the common shown next, so both change on one edge.
  assign pix_base = 5'({3'b000, com_show} * 5'd6);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_q_r <= 1'b0;
      rc_q_r <= 1'b0;
      fast_q_r <= 1'b0;
    end else begin
      timer_q_r <= low_speed_timer_osc_i;
      rc_q_r <= internal_rc_osc_i;
      fast_q_r <= fast_internal_osc_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      post_cnt_r <= 13'h0000;
    end else if (!active) begin
      post_cnt_r <= 13'h0000;
    end else if (src_tick) begin
      post_cnt_r <= (post_cnt_r >= post_limit) ? 13'h0000 : 13'(post_cnt_r + 13'h0001);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_cnt_r <= 4'h0;
    end else if (!active) begin
      pre_cnt_r <= 4'h0;
    end else if (base_tick) begin
      pre_cnt_r <= step ? 4'h0 : 4'(pre_cnt_r + 4'h1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      com_idx_r <= 2'd0;
      common_line_r <= 4'h0;
      frame_tick_r <= 1'b0;
    end else if (!active) begin
      com_idx_r <= 2'd0;
      common_line_r <= 4'h0;
      frame_tick_r <= 1'b0;
    end else begin
      frame_tick_r <= frame_evt;
      if (step) begin
        com_idx_r <= com_nxt;
      end
      common_line_r <= 4'(4'h1 << com_show);
    end
  end

  // One term per segment pin: dark only if the pin is a segment and the bit is set.
  for (genvar s = 0; s < lcdc_pkg::NUM_SEG; s++) begin : g_seg
    localparam int GRP = s / 8;
    localparam int BIT = s % 8;
    assign segment_enable_bit_o[s] = seg_r[GRP][BIT];
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        seg_data_r[s] <= 1'b0;
      end else begin
        seg_data_r[s] <= active && seg_r[GRP][BIT] &&
                         pix_r[5'(pix_base + 5'(GRP))][BIT];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < lcdc_pkg::NUM_PIX_REG; i++) begin
        pix_r[i] <= lcdc_pkg::RST_ZERO;
      end
    end else if (pix_wr) begin
      pix_r[pix_idx] <= wdata_i & pix_mask(pix_idx);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < lcdc_pkg::NUM_SEG_REG; i++) begin
        seg_r[i] <= lcdc_pkg::RST_ZERO;
      end
    end else if (wr_i && is_seg) begin
      seg_r[seg_idx] <= wdata_i & seg_mask(seg_idx);
    end
  end

  // The error flag can only be cleared by writing 0; a new error in the same
  // cycle keeps it set.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= lcdc_pkg::lcdc_ctrl_t'(lcdc_pkg::RST_ZERO);
    end else begin
      if (wr_i && addr_i == lcdc_pkg::OFF_CTRL) begin
        ctrl_r <= lcdc_pkg::lcdc_ctrl_t'((wdata_i & lcdc_pkg::MASK_CTRL_WR) |
                  {2'b00, ctrl_r.write_error_flag & wdata_i[lcdc_pkg::CTRL_WRITE_ERROR_FLAG_BIT], 5'b00000});
      end
      if (write_error_flag_evt) begin
        ctrl_r.write_error_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= lcdc_pkg::lcdc_phase_t'(lcdc_pkg::RST_ZERO);
      regul_r <= lcdc_pkg::lcdc_regul_t'(lcdc_pkg::RST_REGUL);
    end else begin
      if (wr_i && addr_i == lcdc_pkg::OFF_PHASE) begin
        phase_r <= lcdc_pkg::lcdc_phase_t'(wdata_i & lcdc_pkg::MASK_PHASE_WR);
      end
      if (wr_i && addr_i == lcdc_pkg::OFF_REGUL) begin
        regul_r <= lcdc_pkg::lcdc_regul_t'(wdata_i & lcdc_pkg::MASK_REGUL_WR);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_i && addr_i == lcdc_pkg::OFF_IRQ_MASK) begin
        irq_mask_r <= wdata_i[1:0] & lcdc_pkg::MASK_IRQ;
      end
      irq_stat_r <= (rd_stat ? 2'h0 : irq_stat_r) | {frame_evt, write_error_flag_evt};
    end
  end

  // The pump branch runs apart from the frame timing, even when the display is off.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fast_div_r <= 8'h00;
      pump_clk_r <= 1'b0;
    end else begin
      if (fast_tick) begin
        fast_div_r <= 8'(fast_div_r + 8'h01);
      end
      case (regul_r.pump_sel)
        lcdc_pkg::PUMP_RC: pump_clk_r <= internal_rc_osc_i;
        lcdc_pkg::PUMP_FAST: pump_clk_r <= fast_div_r[7];
        lcdc_pkg::PUMP_TIMER: pump_clk_r <= low_speed_timer_osc_i;
        default: pump_clk_r <= 1'b0;
      endcase
    end
  end

  always_comb begin
    rdata_nxt = lcdc_pkg::RST_ZERO;
    if (is_pix) begin
      rdata_nxt = pix_r[pix_idx];
    end else if (is_seg) begin
      rdata_nxt = seg_r[seg_idx];
    end else begin
      case (addr_i)
        lcdc_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
        lcdc_pkg::OFF_PHASE: rdata_nxt = {phase_r.wave_b, phase_r.bias_half, active,
                                          write_allow, phase_r.prescale};
        lcdc_pkg::OFF_REGUL: rdata_nxt = regul_r;
        lcdc_pkg::OFF_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
        lcdc_pkg::OFF_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
        default: rdata_nxt = lcdc_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= lcdc_pkg::RST_ZERO;
    end else begin
      rdata_r <= rd_i ? rdata_nxt : lcdc_pkg::RST_ZERO;
    end
  end

  assign rdata_o = rdata_r;
  assign seg_data_o = seg_data_r;
  assign common_line_o = common_line_r;
  assign display_active_o = active;
  assign frame_tick_o = frame_tick_r;
  assign pump_clk_o = pump_clk_r;
  assign regulator_en_o = (regul_r.pump_sel != lcdc_pkg::PUMP_OFF);
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Helper counters that let the checks measure divider spacing.
  logic [13:0] gap_r;
  logic clean_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r <= 14'h0000;
      clean_r <= 1'b0;
    end else if (base_tick) begin
      gap_r <= 14'h0000;
      clean_r <= 1'b1;
    end else begin
      gap_r <= 14'(gap_r + 14'h0001);
      if (!active || (wr_i && addr_i == lcdc_pkg::OFF_CTRL)) begin
        clean_r <= 1'b0;
      end
    end
  end

  sequence s_pix_wr_blocked;
    wr_i && is_pix && !write_allow;
  endsequence

  sequence s_last_step;
    step && (com_cur == 2'(ctrl_r.mux));
  endsequence

  property p_write_error_flag_set;
    @(posedge clk_i) disable iff (!resetn_i) s_pix_wr_blocked |=> ctrl_r.write_error_flag;
  endproperty
  a_write_error_flag_set: assert property (p_write_error_flag_set) else $error("write error flag not set");

  property p_pix_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      s_pix_wr_blocked ##0 (pix_idx == 5'd0) |=> $stable(pix_r[0]);
  endproperty
  a_pix_hold: assert property (p_pix_hold) else $error("blocked pixel write took effect");

  property p_seg_wr;
    @(posedge clk_i) disable iff (!resetn_i)
      wr_i && addr_i == lcdc_pkg::OFF_SEGEN0 + 6'd1 |=>
      segment_enable_bit_o[15:8] == $past(wdata_i);
  endproperty
  a_seg_wr: assert property (p_seg_wr) else $error("segment enable write misplaced");

  property p_small_absent;
    @(posedge clk_i) disable iff (!resetn_i)
      SMALL_VARIANT |-> segment_enable_bit_o[47:33] == 15'h0000 && seg_data_o[47:33] == 15'h0000;
  endproperty
  a_small_absent: assert property (p_small_absent) else $error("absent segment active");

  property p_reset_clear;
    @(posedge clk_i) !$past(resetn_i) |-> segment_enable_bit_o == 48'h0 && seg_data_o == 48'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");

  property p_post_sys;
    @(posedge clk_i) disable iff (!resetn_i)
      base_tick && clean_r && ctrl_r.clk_src == lcdc_pkg::SRC_SYS |->
      gap_r == 14'(POST_DIV_SYS - 1);
  endproperty
  a_post_sys: assert property (p_post_sys) else $error("system postscaler spacing wrong");

  property p_ring_wrap;
    @(posedge clk_i) disable iff (!resetn_i) s_last_step ##0 active |=> common_line_o == 4'h1;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) else $error("common ring did not wrap");

  property p_static_one;
    @(posedge clk_i) disable iff (!resetn_i)
      ctrl_r.mux == lcdc_pkg::MUX_STATIC && $past(ctrl_r.mux) == lcdc_pkg::MUX_STATIC
      |-> common_line_o[3:1] == 3'h0;
  endproperty
  a_static_one: assert property (p_static_one) else $error("static mode used extra common");

  property p_pump_rc;
    @(posedge clk_i) disable iff (!resetn_i)
      regul_r.pump_sel == lcdc_pkg::PUMP_RC ##1 regul_r.pump_sel == lcdc_pkg::PUMP_RC
      |-> pump_clk_o == $past(internal_rc_osc_i);
  endproperty
  a_pump_rc: assert property (p_pump_rc) else $error("pump clock not from RC source");

  property p_pump_off;
    @(posedge clk_i) disable iff (!resetn_i)
      regul_r.pump_sel == lcdc_pkg::PUMP_OFF [*2] |-> !pump_clk_o && !regulator_en_o;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump clock running while off");

  property p_irq_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      rd_stat && !write_error_flag_evt && !frame_evt |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read did not clear interrupt");

endmodule : lcdc_core

// [hw/lcdc_pkg.sv]
package lcdc_pkg;

  localparam int NUM_SEG_REG = 6;
  localparam int NUM_PIX_REG = 24;
  localparam int PIX_PER_COM = 6;
  localparam int NUM_COM = 4;
  localparam int NUM_SEG = 48;
  localparam int ADDR_W = 6;

  localparam logic [5:0] OFF_PIX0 = 6'h00;
  localparam logic [5:0] OFF_SEGEN0 = 6'h18;
  localparam logic [5:0] OFF_CTRL = 6'h1e;
  localparam logic [5:0] OFF_PHASE = 6'h1f;
  localparam logic [5:0] OFF_REGUL = 6'h20;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h21;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h22;

  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_REGUL = 8'h3c;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_SEG32 = 8'h01;
  localparam logic [7:0] MASK_CTRL_WR = 8'hcf;
  localparam logic [7:0] MASK_PHASE_WR = 8'hcf;
  localparam logic [7:0] MASK_REGUL_WR = 8'h7f;
  localparam logic [1:0] MASK_IRQ = 2'h3;

  localparam int CTRL_WRITE_ERROR_FLAG_BIT = 5;
  localparam int IRQ_WRITE_ERROR_FLAG_BIT = 0;
  localparam int IRQ_FRAME_BIT = 1;

  localparam int POST_DIV_SYS = 8192;
  localparam int POST_DIV_SLOW = 32;
  localparam int PUMP_FAST_DIV = 256;

  typedef enum logic [1:0] {MUX_STATIC, MUX_HALF, MUX_THIRD, MUX_QUARTER} lcdc_mux_t;
  typedef enum logic [1:0] {PUMP_OFF, PUMP_TIMER, PUMP_FAST, PUMP_RC} lcdc_pump_t;
  typedef enum logic [1:0] {SRC_SYS, SRC_TIMER, SRC_RC_A, SRC_RC_B} lcdc_src_t;

  typedef struct packed {
    logic en;
    logic sleep_off;
    logic write_error_flag;
    logic rsvd;
    lcdc_src_t clk_src;
    lcdc_mux_t mux;
  } lcdc_ctrl_t;

  typedef struct packed {
    logic wave_b;
    logic bias_half;
    logic active;
    logic write_allow;
    logic [3:0] prescale;
  } lcdc_phase_t;

  typedef struct packed {
    logic rsvd;
    logic pump_en;
    logic [2:0] bias;
    logic mode13;
    lcdc_pump_t pump_sel;
  } lcdc_regul_t;

endpackage : lcdc_pkg

// [verif/lcdc_core_tb.sv]
`timescale 1ns/10ps
module lcdc_core_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic tmr_osc = 1'b0;
  logic rc_osc = 1'b0;
  logic fast_osc = 1'b0;
  logic [7:0] rdata_o, rdata_small;
  logic [47:0] seg_en, seg_data, seg_en_small;
  logic [3:0] com;
  logic active, frame_tick, pump_clk, reg_en, irq;
  logic [3:0][47:0] image;
  int n_errors = 0;
  int check_count = 0;
  int tmr_cnt = 0;
  int rc_cnt = 0;
  logic [7:0] segv [6] = '{8'h0f, 8'hff, 8'ha5, 8'hff, 8'h3c, 8'hff};
  logic [7:0] ctl_tab [5] = '{8'h81, 8'h81, 8'h85, 8'h89, 8'h8d};
  logic [7:0] ps_tab [5] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
  int per_tab [5] = '{32, 512, 48, 80, 80};
  int pump_tab [4] = '{0, 6, 512, 10};

  lcdc_core #(.POST_DIV_SYS(16), .POST_DIV_SLOW(4)) lcdc_core_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
    .low_speed_timer_osc_i(tmr_osc), .internal_rc_osc_i(rc_osc),
    .fast_internal_osc_i(fast_osc), .segment_enable_bit_o(seg_en), .seg_data_o(seg_data),
    .common_line_o(com), .display_active_o(active), .frame_tick_o(frame_tick),
    .pump_clk_o(pump_clk), .regulator_en_o(reg_en), .irq_o(irq));
  lcdc_core #(.SMALL_VARIANT(1'b1), .POST_DIV_SYS(16), .POST_DIV_SLOW(4)) lcdc_core_small_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_small), .sleep_i(sleep_i),
    .low_speed_timer_osc_i(tmr_osc), .internal_rc_osc_i(rc_osc),
    .fast_internal_osc_i(fast_osc), .segment_enable_bit_o(seg_en_small), .seg_data_o(),
    .common_line_o(), .display_active_o(), .frame_tick_o(), .pump_clk_o(),
    .regulator_en_o(), .irq_o());
  lcdc_panel_model lcdc_panel_model_inst (
    .clk_i(clk_i), .seg_data_i(seg_data), .common_line_i(com), .image_o(image));

  initial forever #10 clk_i = ~clk_i;

  // Oscillators run at fixed fractions of the bus clock so every period is exact in cycles.
  always @(posedge clk_i) begin
    tmr_cnt <= (tmr_cnt == 2) ? 0 : tmr_cnt + 1;
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    if (tmr_cnt == 2) tmr_osc <= ~tmr_osc;
    if (rc_cnt == 4) rc_osc <= ~rc_osc;
    fast_osc <= ~fast_osc;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 29 + 5);
  endfunction : pat

  function automatic logic [7:0] smask(input int k);
    return (k < 4) ? 8'hff : ((k == 4) ? 8'h01 : 8'h00);
  endfunction : smask

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_per(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_per

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr_reg

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d, output logic [7:0] ds);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    ds = rdata_small;
    @(posedge clk_i);
  endtask : rd_reg

  task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp,
                        input logic [7:0] m);
    logic [7:0] d, ds;
    rd_reg(a, d, ds);
    chk_reg(what, exp & m, d & m);
  endtask : rd_chk

  task automatic rd_pair(input string what, input logic [5:0] a, input logic [7:0] exp,
                         input int k);
    logic [7:0] d, ds;
    rd_reg(a, d, ds);
    chk_reg(what, exp, d);
    chk_reg({what, "_small"}, exp & smask(k), ds);
  endtask : rd_pair

  // Skips two rising edges so the interval measured lies wholly under the new setting.
  task automatic measure(input bit pump, output int per);
    logic s, prev;
    int n;
    n = 0;
    per = 0;
    prev = 1'b1;
    repeat (3000) begin
      @(posedge clk_i);
      #1;
      s = pump ? pump_clk : com[0];
      if (n == 2) per++;
      if (s === 1'b1 && prev === 1'b0) n++;
      prev = s;
      if (n == 3) break;
    end
    @(posedge clk_i);
  endtask : measure

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1000000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    int per, ticks, bad;
    logic [3:0] seen;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 30; i++) rd_pair("reset", 6'(i), 8'h00, 0);
    rd_chk("regul_reset", lcdc_pkg::OFF_REGUL, lcdc_pkg::RST_REGUL, 8'hff);
    wr_reg(6'h3f, 8'hff);
    rd_chk("unmapped", 6'h3f, 8'h00, 8'hff);
    for (int k = 0; k < 6; k++) begin
      wr_reg(lcdc_pkg::OFF_SEGEN0 + 6'(k), segv[k]);
      chk_reg("seg_pins", segv[k], seg_en[8*k +: 8]);
      rd_pair("seg_en", lcdc_pkg::OFF_SEGEN0 + 6'(k), segv[k], k);
    end
    chk_reg("small_pins_hi", 8'h00, seg_en_small[47:40]);
    chk_reg("small_pins_mid", 8'h00, {1'b0, seg_en_small[39:33]});
    for (int i = 0; i < 24; i++) wr_reg(6'(i), pat(i));
    for (int i = 0; i < 24; i++) rd_pair("pixel", 6'(i), pat(i), i % 6);
    wr_reg(lcdc_pkg::OFF_CTRL, 8'h83);
    rd_chk("phase_active", lcdc_pkg::OFF_PHASE, 8'h20, 8'h2f);
    repeat (200) @(posedge clk_i);
    for (int y = 0; y < 4; y++) begin
      for (int k = 0; k < 6; k++) begin
        chk_reg("image", pat(6*y + k) & segv[k], image[y][8*k +: 8]);
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr_reg(lcdc_pkg::OFF_CTRL, 8'h80 | 8'(m));
      repeat (70) @(posedge clk_i);
      seen = 4'h0;
      ticks = 0;
      bad = 0;
      repeat (960) begin
        @(posedge clk_i);
        #1;
        seen = seen | com;
        if (frame_tick === 1'b1) ticks++;
        if ($onehot(com) !== 1'b1) bad++;
      end
      chk_reg("commons", 8'((1 << (m + 1)) - 1), {4'h0, seen});
      chk_per("onehot", 0, bad);
      chk_per("frames", 960 / (16 * (m + 1)), ticks);
    end
    for (int j = 0; j < 5; j++) begin
      wr_reg(lcdc_pkg::OFF_CTRL, ctl_tab[j]);
      wr_reg(lcdc_pkg::OFF_PHASE, ps_tab[j]);
      measure(1'b0, per);
      chk_per("step_period", per_tab[j], per);
    end
    wr_reg(lcdc_pkg::OFF_REGUL, 8'h3c);
    chk_reg("regulator_off", 8'h00, {7'h0, reg_en});
    for (int s = 1; s < 4; s++) begin
      wr_reg(lcdc_pkg::OFF_REGUL, 8'h3c | 8'(s));
      chk_reg("regulator_on", 8'h01, {7'h0, reg_en});
      measure(1'b1, per);
      chk_per("pump_period", pump_tab[s], per);
    end
    wr_reg(lcdc_pkg::OFF_CTRL, 8'h81);
    wr_reg(lcdc_pkg::OFF_PHASE, 8'h00);
    wr_reg(lcdc_pkg::OFF_IRQ_MASK, 8'h01);
    rd_chk("no_early_error", lcdc_pkg::OFF_IRQ_STAT, 8'h00, 8'h01);
    chk_reg("irq_quiet", 8'h00, {7'h0, irq});
    // A burst longer than one common step is sure to collide with a step.
    addr_i <= 6'h00;
    wdata_i <= pat(0);
    wr_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
    chk_reg("irq_set", 8'h01, {7'h0, irq});
    rd_chk("write_error_flag", lcdc_pkg::OFF_CTRL, 8'h20, 8'h20);
    rd_chk("stat_write_error_flag", lcdc_pkg::OFF_IRQ_STAT, 8'h01, 8'h01);
    chk_reg("irq_clear", 8'h00, {7'h0, irq});
    rd_chk("write_error_flag_sticky", lcdc_pkg::OFF_CTRL, 8'h20, 8'h20);
    wr_reg(lcdc_pkg::OFF_CTRL, 8'h81);
    rd_chk("write_error_flag_cleared", lcdc_pkg::OFF_CTRL, 8'h00, 8'h20);
    rd_chk("pixel_kept", 6'h00, pat(0), 8'hff);
    wr_reg(lcdc_pkg::OFF_IRQ_MASK, 8'h02);
    repeat (100) @(posedge clk_i);
    chk_reg("irq_frame", 8'h01, {7'h0, irq});
    wr_reg(lcdc_pkg::OFF_CTRL, 8'hc1);
    sleep_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_reg("sleep_off", 8'h00, {3'h0, active, com});
    sleep_i <= 1'b0;
    @(posedge clk_i);
    report_and_stop();
  end
endmodule : lcdc_core_tb

// [verif/lcdc_panel_model.sv]
`timescale 1ns/10ps
// Keeps the last segment pattern shown under each common, as the glass would show it.
// Pins in digital I/O mode are not masked here, so a leak through a disabled pin shows.
module lcdc_panel_model (
  input wire logic clk_i,
  input wire logic [47:0] seg_data_i,
  input wire logic [3:0] common_line_i,
  output logic [3:0][47:0] image_o
);
  always @(posedge clk_i) begin
    for (int y = 0; y < 4; y++) begin
      if (common_line_i == (4'h1 << y)) begin
        image_o[y] <= seg_data_i;
      end
    end
  end
endmodule : lcdc_panel_model
